/* File: dct_defs.svh */
/*
  Register indices, reset values, limits and timing counts of the cyclic
  telegram timing block, as plain macros.
  Assumes a 10 MHz ref_clk_i; included by bare name wherever needed.
*/
`ifndef DCT_DEFS_SVH
`define DCT_DEFS_SVH

// parameter indices on the parameter access port
`define IDX_CYCLE_PERIOD 16'h0002
`define IDX_MIN_ANSWER_DELAY 16'h0003
`define IDX_TX_RX_GAP 16'h0004
`define IDX_FEEDBACK_PROCESS 16'h0005
`define IDX_ANSWER_SEND_OFFSET 16'h0006
`define IDX_FEEDBACK_CAPTURE 16'h0007
`define IDX_COMMAND_VALID 16'h0008
`define IDX_RECORD_BYTE_OFFSET 16'h0009
`define IDX_MASTER_DATA_LENGTH 16'h000A

// reset values, microseconds
`define RST_CYCLE_PERIOD 16'h07D0
`define RST_MIN_ANSWER_DELAY 16'h0028
`define RST_TX_RX_GAP 16'h0028
`define RST_FEEDBACK_PROCESS 16'h00C8
`define RST_UNSET 16'h0000

// limits
`define CYCLE_MIN_US 16'h03E8
`define CYCLE_MAX_US 16'h1F40
`define CYCLE_STEP_US 16'h03E8
`define INTERP_MAX_CYCLE_US 16'h0FA0
`define INTERP_STEP_US 16'h00FA
`define RECORD_OFFSET_MAX 16'hFFFB
`define DATA_LENGTH_MIN 16'h0004
`define DATA_LENGTH_MAX 16'hFFFE

// communication phases
`define PHASE_LOAD 3'h2
`define PHASE_RUN 3'h3
`define PHASE_OPERATE 3'h4

// time base
`define CLK_PERIOD_NS 100
`define MICROSECOND_NS 1000
`define CYCLES_PER_US ((`MICROSECOND_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// record buffer
`define REC_FIFO_WIDTH 8
`define REC_FIFO_DEPTH 8

`endif

/* File: dct_pkg.sv */
/*
  Types shared by the cyclic telegram timing block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package dct_pkg;

  // gray codes along idle -> seek -> take
  typedef enum logic [1:0] {
    MDT_IDLE = 2'b00,
    MDT_SEEK = 2'b01,
    MDT_TAKE = 2'b11
  } mdt_state_t;

  typedef struct packed {
    logic [2:0] phase_prev;
    logic [15:0] cycle_period;
    logic [15:0] answer_ofs;
    logic [15:0] fb_capture;
    logic [15:0] cmd_valid_time;
    logic [15:0] rec_ofs;
    logic [15:0] mdt_len;
    logic capture_set;
    logic [15:0] act_period;
    logic [15:0] act_answer;
    logic [15:0] act_capture;
    logic [15:0] act_cmd;
    logic [15:0] act_rec_ofs;
    logic [15:0] act_len;
    logic [3:0] presc;
    logic [15:0] us_cnt;
    logic [15:0] interp_cnt;
    mdt_state_t mdt_state;
    logic [15:0] mdt_idx;
    logic [15:0] rdata;
    logic ack;
    logic err;
    logic cycle_start;
    logic sync_missed;
    logic answer_start;
    logic fb_latch;
    logic cmd_valid;
    logic interp_step;
    logic interp_en;
    logic overflow;
  } timing_state_t;

endpackage
`default_nettype wire

/* File: rec_fifo_if.sv */
/*
  Valid/ready carrier between the timing block and its record buffer.
  Assumes one clock for both sides.
*/
`default_nettype none
interface rec_fifo_if #(parameter int WIDTH = 8);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport buffer (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

/* File: rec_fifo.sv */
/*
  Shift-register FIFO for record bytes; head word, empty and full flags
  all come straight from flip-flops.
  Assumes synchronous push and pop on one clock, active-low async reset.
*/
`default_nettype none
module rec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  rec_fifo_if.buffer port
);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] count;
    logic has_data;
    logic has_room;
  } fifo_state_t;

  fifo_state_t st, next_st;
  logic do_push, do_pop;
  logic [CW-1:0] wr_idx;

  assign do_push = port.push_valid && st.has_room;
  assign do_pop = port.pop_ready && st.has_data;
  assign port.push_ready = st.has_room;
  assign port.pop_valid = st.has_data;
  assign port.pop_data = st.mem[0];

  always_comb begin
    next_st = st;
    wr_idx = st.count;
    if (do_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_st.mem[i] = st.mem[i+1];
      end
      wr_idx = st.count - CW'(1);
    end
    if (do_push) begin
      next_st.mem[wr_idx] = port.push_data;
    end
    next_st.count = st.count + CW'(do_push) - CW'(do_pop);
    next_st.has_data = (next_st.count != '0);
    next_st.has_room = (next_st.count != CW'(DEPTH));
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '{mem: '0, count: '0, has_data: 1'b0, has_room: 1'b1};
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

/* File: drive_cyclic_telegram_timing.sv */
/*
  Drive-side timing and framing of the cyclic ring: phase-2 parameter
  store, microsecond cycle timer started by each sync end, answer /
  feedback / command / interpolation strobes, and record extraction from
  the master data telegram into a small FIFO.
  Assumes inputs synchronous to ref_clk_i (10 MHz), phase given by the
  ring controller, and a byte stream whose first byte is the address field.

// Functional notes
// - sequence repeats once per configured cycle period
// - cycle period 1 to 8 ms, whole ms
// - 250 us interpolation for 1 to 4 ms
// - minimum answer delay readable, default 40 us
// - answer-to-data gap readable, default 40 us
// - feedback processing time readable, default 200 us
// - answer starts at offset in phases 3, 4
// - feedback latched at capture time, bounded, defaulted
// - commands used from valid time, bounded
// - record found at byte offset from address
// - record offset loaded phase 2, used phase 3
// - length counts data field bytes only
// - data length loaded phase 2, used phase 3
*/
`default_nettype none
`include "dct_defs.svh"
module drive_cyclic_telegram_timing (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] comm_phase_i,
  input wire logic mst_end_i,
  input wire logic [7:0] mdt_byte_i,
  input wire logic mdt_valid_i,
  input wire logic mdt_sof_i,
  input wire logic [15:0] mdt_start_time_us_i,
  input wire logic [15:0] mdt_duration_us_i,
  input wire logic [15:0] cmd_process_time_us_i,
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  input wire logic [15:0] param_idn_i,
  input wire logic [15:0] param_wdata_i,
  input wire logic rec_ready_i,
  output logic [15:0] param_rdata_o,
  output logic param_ack_o,
  output logic param_err_o,
  output logic cycle_start_o,
  output logic sync_missed_o,
  output logic answer_start_o,
  output logic feedback_latch_o,
  output logic cmd_valid_o,
  output logic interp_step_o,
  output logic interp_enable_o,
  output logic mdt_ready_o,
  output logic [7:0] rec_data_o,
  output logic rec_valid_o,
  output logic rec_overflow_o
);
  localparam logic [3:0] PRESCALE_LAST = 4'(`CYCLES_PER_US - 1);

  dct_pkg::timing_state_t st, next_st;

  rec_fifo_if #(.WIDTH(`REC_FIFO_WIDTH)) fifo_port ();

  rec_fifo #(
    .WIDTH(`REC_FIFO_WIDTH),
    .DEPTH(`REC_FIFO_DEPTH)
  ) u_rec_fifo (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .port(fifo_port.buffer)
  );

  // range checks of each writable parameter
  logic cycle_ok, answer_ok, capture_ok;
  logic cmd_ok, rec_ok, len_ok;
  logic [16:0] answer_hi;
  logic [16:0] capture_sum;
  logic [17:0] cmd_lo;
  logic in_load, in_run, us_tick;
  logic phase3_entry, take_byte;
  logic [15:0] us_next;
  logic [15:0] interp_next;

  always_comb begin
    cycle_ok = (param_wdata_i >= `CYCLE_MIN_US) && (param_wdata_i <= `CYCLE_MAX_US)
      && ((param_wdata_i % `CYCLE_STEP_US) == 16'h0000);
    answer_hi = {1'b0, param_wdata_i} + {1'b0, `RST_TX_RX_GAP};
    answer_ok = (param_wdata_i > `RST_MIN_ANSWER_DELAY)
      && (answer_hi < {1'b0, mdt_start_time_us_i});
    capture_sum = {1'b0, param_wdata_i} + {1'b0, `RST_FEEDBACK_PROCESS};
    capture_ok = (capture_sum <= {1'b0, st.cycle_period});
    cmd_lo = {2'b00, mdt_start_time_us_i} + {2'b00, mdt_duration_us_i}
      + {2'b00, cmd_process_time_us_i};
    cmd_ok = (cmd_lo < {2'b00, param_wdata_i})
      && (param_wdata_i <= st.cycle_period);
    // an odd offset is never zero, so no separate nonzero test
    rec_ok = param_wdata_i[0]
      && (param_wdata_i <= `RECORD_OFFSET_MAX);
    len_ok = !param_wdata_i[0] && (param_wdata_i >= `DATA_LENGTH_MIN)
      && (param_wdata_i <= `DATA_LENGTH_MAX);
  end

  assign in_load = (comm_phase_i == `PHASE_LOAD);
  assign in_run = (comm_phase_i == `PHASE_RUN)
    || (comm_phase_i == `PHASE_OPERATE);
  assign phase3_entry = (comm_phase_i == `PHASE_RUN)
    && (st.phase_prev != `PHASE_RUN);
  assign us_tick = (st.presc == PRESCALE_LAST);
  assign us_next = st.us_cnt + 16'h0001;
  assign interp_next = st.interp_cnt + 16'h0001;

  // a record byte lies between the offset and the end of the data field
  assign take_byte = mdt_valid_i && !mdt_sof_i
    && (st.mdt_state == dct_pkg::MDT_TAKE);
  assign fifo_port.push_valid = take_byte;
  assign fifo_port.push_data = mdt_byte_i;
  assign fifo_port.pop_ready = rec_ready_i;

  always_comb begin
    next_st = st;
    next_st.phase_prev = comm_phase_i;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    next_st.cycle_start = 1'b0;
    next_st.answer_start = 1'b0;
    next_st.fb_latch = 1'b0;
    next_st.cmd_valid = 1'b0;
    next_st.interp_step = 1'b0;

    // parameter access: writes only in phase 2 and only within limits
    if (param_wr_i) begin
      next_st.ack = 1'b1;
      if (!in_load) begin
        next_st.err = 1'b1;
      end else begin
        unique case (param_idn_i)
          `IDX_CYCLE_PERIOD: begin
            if (cycle_ok) begin
              next_st.cycle_period = param_wdata_i;
              // capture point follows its default until written
              if (!st.capture_set) begin
                next_st.fb_capture = param_wdata_i - `RST_FEEDBACK_PROCESS;
              end
            end else begin
              next_st.err = 1'b1;
            end
          end
          `IDX_ANSWER_SEND_OFFSET: begin
            if (answer_ok) next_st.answer_ofs = param_wdata_i;
            else next_st.err = 1'b1;
          end
          `IDX_FEEDBACK_CAPTURE: begin
            if (capture_ok) begin
              next_st.fb_capture = param_wdata_i;
              next_st.capture_set = 1'b1;
            end else begin
              next_st.err = 1'b1;
            end
          end
          `IDX_COMMAND_VALID: begin
            if (cmd_ok) next_st.cmd_valid_time = param_wdata_i;
            else next_st.err = 1'b1;
          end
          `IDX_RECORD_BYTE_OFFSET: begin
            if (rec_ok) next_st.rec_ofs = param_wdata_i;
            else next_st.err = 1'b1;
          end
          `IDX_MASTER_DATA_LENGTH: begin
            if (len_ok) next_st.mdt_len = param_wdata_i;
            else next_st.err = 1'b1;
          end
          default: begin
            // read-only figures and unknown indices refuse writes
            next_st.err = 1'b1;
          end
        endcase
      end
    end else if (param_rd_i) begin
      next_st.ack = 1'b1;
      unique case (param_idn_i)
        `IDX_CYCLE_PERIOD: next_st.rdata = st.cycle_period;
        `IDX_MIN_ANSWER_DELAY: next_st.rdata = `RST_MIN_ANSWER_DELAY;
        `IDX_TX_RX_GAP: next_st.rdata = `RST_TX_RX_GAP;
        `IDX_FEEDBACK_PROCESS: next_st.rdata = `RST_FEEDBACK_PROCESS;
        `IDX_ANSWER_SEND_OFFSET: next_st.rdata = st.answer_ofs;
        `IDX_FEEDBACK_CAPTURE: next_st.rdata = st.fb_capture;
        `IDX_COMMAND_VALID: next_st.rdata = st.cmd_valid_time;
        `IDX_RECORD_BYTE_OFFSET: next_st.rdata = st.rec_ofs;
        `IDX_MASTER_DATA_LENGTH: next_st.rdata = st.mdt_len;
        default: begin
          next_st.rdata = 16'h0000;
          next_st.err = 1'b1;
        end
      endcase
    end

    // loaded values take effect only on entry to phase 3, so a half-written
    // set in phase 2 never reaches the running timer
    if (phase3_entry) begin
      next_st.act_period = st.cycle_period;
      next_st.act_answer = st.answer_ofs;
      next_st.act_capture = st.fb_capture;
      next_st.act_cmd = st.cmd_valid_time;
      next_st.act_rec_ofs = st.rec_ofs;
      next_st.act_len = st.mdt_len;
    end

    next_st.interp_en = (st.act_period <= `INTERP_MAX_CYCLE_US);

    // microsecond timer referenced to the end of the sync telegram
    if (mst_end_i) begin
      next_st.presc = 4'h0;
      next_st.us_cnt = 16'h0000;
      next_st.interp_cnt = 16'h0000;
      next_st.cycle_start = 1'b1;
      next_st.sync_missed = 1'b0;
      next_st.interp_step = st.interp_en;
    end else begin
      next_st.presc = us_tick ? 4'h0 : st.presc + 4'h1;
      if (us_tick) begin
        next_st.us_cnt = us_next;
        next_st.interp_cnt = interp_next;
        if (interp_next == `INTERP_STEP_US) begin
          next_st.interp_cnt = 16'h0000;
          next_st.interp_step = st.interp_en;
        end
        if (in_run && (us_next == st.act_answer)) begin
          next_st.answer_start = 1'b1;
        end
        if (in_run && (us_next == st.act_capture)) begin
          next_st.fb_latch = 1'b1;
        end
        if (in_run && (us_next == st.act_cmd)) begin
          next_st.cmd_valid = 1'b1;
        end
        // no sync within one period: flag it and keep the cycle running;
        // >= also wraps a count left above a shorter newly active period
        if (us_next >= st.act_period) begin
          next_st.us_cnt = 16'h0000;
          next_st.interp_cnt = 16'h0000;
          next_st.cycle_start = 1'b1;
          next_st.sync_missed = 1'b1;
        end
      end
    end

    // master data telegram: index 0 is the address field, data follows
    if (mdt_valid_i) begin
      if (mdt_sof_i) begin
        next_st.mdt_idx = 16'h0000;
        next_st.overflow = 1'b0;
        next_st.mdt_state = (in_run && (st.act_rec_ofs == 16'h0001))
          ? dct_pkg::MDT_TAKE : dct_pkg::MDT_SEEK;
        if (!in_run) next_st.mdt_state = dct_pkg::MDT_IDLE;
      end else begin
        next_st.mdt_idx = st.mdt_idx + 16'h0001;
        unique case (st.mdt_state)
          dct_pkg::MDT_IDLE: begin
            next_st.mdt_state = dct_pkg::MDT_IDLE;
          end
          dct_pkg::MDT_SEEK: begin
            if (st.mdt_idx + 16'h0001 == st.act_rec_ofs - 16'h0001) begin
              next_st.mdt_state = dct_pkg::MDT_TAKE;
            end
            if (st.mdt_idx + 16'h0001 >= st.act_len) begin
              next_st.mdt_state = dct_pkg::MDT_IDLE;
            end
          end
          dct_pkg::MDT_TAKE: begin
            // the data field ends at index length; delimiters and crc excluded
            if (st.mdt_idx + 16'h0001 >= st.act_len) begin
              next_st.mdt_state = dct_pkg::MDT_IDLE;
            end
          end
          default: next_st.mdt_state = dct_pkg::MDT_IDLE;
        endcase
        if (take_byte && !fifo_port.push_ready) begin
          next_st.overflow = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '{
        phase_prev: 3'h0,
        cycle_period: `RST_CYCLE_PERIOD,
        answer_ofs: `RST_UNSET,
        fb_capture: `RST_CYCLE_PERIOD - `RST_FEEDBACK_PROCESS,
        cmd_valid_time: `RST_UNSET,
        rec_ofs: `RST_UNSET,
        mdt_len: `RST_UNSET,
        capture_set: 1'b0,
        act_period: `RST_CYCLE_PERIOD,
        act_answer: `RST_UNSET,
        act_capture: `RST_CYCLE_PERIOD - `RST_FEEDBACK_PROCESS,
        act_cmd: `RST_UNSET,
        act_rec_ofs: `RST_UNSET,
        act_len: `RST_UNSET,
        presc: 4'h0,
        us_cnt: 16'h0000,
        interp_cnt: 16'h0000,
        mdt_state: dct_pkg::MDT_IDLE,
        mdt_idx: 16'h0000,
        rdata: 16'h0000,
        ack: 1'b0,
        err: 1'b0,
        cycle_start: 1'b0,
        sync_missed: 1'b0,
        answer_start: 1'b0,
        fb_latch: 1'b0,
        cmd_valid: 1'b0,
        interp_step: 1'b0,
        interp_en: 1'b1,
        overflow: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  assign param_rdata_o = st.rdata;
  assign param_ack_o = st.ack;
  assign param_err_o = st.err;
  assign cycle_start_o = st.cycle_start;
  assign sync_missed_o = st.sync_missed;
  assign answer_start_o = st.answer_start;
  assign feedback_latch_o = st.fb_latch;
  assign cmd_valid_o = st.cmd_valid;
  assign interp_step_o = st.interp_step;
  assign interp_enable_o = st.interp_en;
  assign mdt_ready_o = fifo_port.push_ready;
  assign rec_data_o = fifo_port.pop_data;
  assign rec_valid_o = fifo_port.pop_valid;
  assign rec_overflow_o = st.overflow;
endmodule
`default_nettype wire

/* File: dct_checker_properties.sv */
/*
  Port checker of the cyclic telegram timing block, bound to its top.
  Assumes one clock domain and the limits held in dct_defs.svh.
*/
`default_nettype none
`include "dct_defs.svh"
module dct_checker (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] comm_phase_i,
  input wire logic mst_end_i,
  input wire logic param_wr_i,
  input wire logic param_rd_i,
  input wire logic [15:0] param_idn_i,
  input wire logic [15:0] param_wdata_i,
  input wire logic [15:0] param_rdata_o,
  input wire logic param_ack_o,
  input wire logic param_err_o,
  input wire logic cycle_start_o,
  input wire logic sync_missed_o,
  input wire logic answer_start_o,
  input wire logic feedback_latch_o,
  input wire logic cmd_valid_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic rd_only;
  assign rd_only = param_rd_i && !param_wr_i;
  property p_ack; (param_wr_i || param_rd_i) |=> param_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_phase;
    param_wr_i && comm_phase_i != `PHASE_LOAD |=> param_err_o && param_ack_o;
  endproperty
  a_phase: assert property (p_phase) else $error("off-phase write kept");
  property p_ro; param_wr_i && param_idn_i inside {[3:5]} |=> param_err_o; endproperty
  a_ro: assert property (p_ro) else $error("read-only write kept");
  property p_period;
    param_wr_i && param_idn_i == `IDX_CYCLE_PERIOD && (param_wdata_i < `CYCLE_MIN_US ||
      param_wdata_i > `CYCLE_MAX_US || param_wdata_i % `CYCLE_STEP_US != 0) |=> param_err_o;
  endproperty
  a_period: assert property (p_period) else $error("bad period kept");
  property p_odd;
    param_wr_i && param_idn_i == `IDX_RECORD_BYTE_OFFSET && !param_wdata_i[0] |=> param_err_o;
  endproperty
  a_odd: assert property (p_odd) else $error("even record offset kept");
  property p_even;
    param_wr_i && param_idn_i == `IDX_MASTER_DATA_LENGTH && param_wdata_i[0] |=> param_err_o;
  endproperty
  a_even: assert property (p_even) else $error("odd length kept");
  property p_delay;
    rd_only && param_idn_i == `IDX_MIN_ANSWER_DELAY |=> param_rdata_o == `RST_MIN_ANSWER_DELAY;
  endproperty
  a_delay: assert property (p_delay) else $error("answer delay value");
  property p_fbproc;
    rd_only && param_idn_i == `IDX_FEEDBACK_PROCESS |=> param_rdata_o == `RST_FEEDBACK_PROCESS;
  endproperty
  a_fbproc: assert property (p_fbproc) else $error("feedback time value");
  property p_cycle; mst_end_i |=> cycle_start_o && !sync_missed_o; endproperty
  a_cycle: assert property (p_cycle) else $error("sync not followed");
  property p_event;
    answer_start_o || feedback_latch_o || cmd_valid_o |->
      $past(comm_phase_i) inside {`PHASE_RUN, `PHASE_OPERATE};
  endproperty
  a_event: assert property (p_event) else $error("event outside run phases");
  c_wr_ok: cover property (param_ack_o && !param_err_o);
  c_answer: cover property (answer_start_o);
  c_missed: cover property (sync_missed_o);
endmodule
bind drive_cyclic_telegram_timing dct_checker u_dct_checker (.ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i), .comm_phase_i(comm_phase_i), .mst_end_i(mst_end_i),
  .param_wr_i(param_wr_i), .param_rd_i(param_rd_i), .param_idn_i(param_idn_i),
  .param_wdata_i(param_wdata_i), .param_rdata_o(param_rdata_o), .param_ack_o(param_ack_o),
  .param_err_o(param_err_o), .cycle_start_o(cycle_start_o), .sync_missed_o(sync_missed_o),
  .answer_start_o(answer_start_o), .feedback_latch_o(feedback_latch_o),
  .cmd_valid_o(cmd_valid_o));
`default_nettype wire

/* File: ring_master_model.sv */
/*
  Behavioural ring master: sync ends and master data telegrams.
  Assumes the bench calls its tasks; drives at the falling edge.
*/
`default_nettype none
module ring_master_model (
  input wire logic ref_clk_i,
  output logic mst_end_o,
  output logic [7:0] byte_o,
  output logic valid_o,
  output logic sof_o,
  output logic [15:0] start_us_o,
  output logic [15:0] dur_us_o,
  output logic [15:0] proc_us_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    mst_end_o = 1'b0;
    byte_o = 8'hA5;
    valid_o = 1'b0;
    sof_o = 1'b0;
    start_us_o = 16'h01F4;
    dur_us_o = 16'h0064;
    proc_us_o = 16'h0032;
  end
  task automatic sync_pulse();
    @(negedge ref_clk_i);
    mst_end_o = 1'b1;
    @(negedge ref_clk_i);
    mst_end_o = 1'b0;
  endtask
  // byte k of telegram t carries {t, k}; a released line shows the inverse
  task automatic send_mdt(input logic [3:0] t, input int n);
    for (int i = 0; i <= n; i++) begin
      @(negedge ref_clk_i);
      sof_o = (i == 0);
      valid_o = 1'b1;
      byte_o = {t, 4'(i)};
    end
    @(negedge ref_clk_i);
    valid_o = 1'b0;
    sof_o = 1'b0;
    byte_o = ~byte_o;
  endtask
endmodule
`default_nettype wire

/* File: drive_cyclic_telegram_timing_tb.sv */
/*
  Self-checking bench of the cyclic telegram timing block.
  Assumes the ring master model and the bound port checker.
*/
`default_nettype none
`include "dct_defs.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module drive_cyclic_telegram_timing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] comm_phase_i = 3'h0;
  logic param_wr_i = 1'b0;
  logic param_rd_i = 1'b0;
  logic [15:0] param_idn_i = 16'h0000;
  logic [15:0] param_wdata_i = 16'h0000;
  logic rec_ready_i = 1'b0;
  wire logic mst_end, mdt_valid, mdt_sof;
  wire logic [7:0] mdt_byte;
  wire logic [15:0] t_start, t_dur, t_proc;
  logic [15:0] param_rdata_o;
  logic param_ack_o, param_err_o, cycle_start_o, sync_missed_o, answer_start_o;
  logic feedback_latch_o, cmd_valid_o, interp_step_o, interp_enable_o, mdt_ready_o;
  logic [7:0] rec_data_o;
  logic rec_valid_o, rec_overflow_o;
  int bad_count = 0;
  int n_tests = 0;
  int t_ans = 0, t_fb = 0, t_cmd = 0, n_int = 0, n_cyc = 0;
  // {index, value, refused}
  logic [32:0] rst_tab [11] = '{{16'h2, 16'h07D0, 1'b0}, {16'h3, 16'h0028, 1'b0},
    {16'h4, 16'h0028, 1'b0}, {16'h5, 16'h00C8, 1'b0}, {16'h6, 16'h0, 1'b0},
    {16'h7, 16'h0708, 1'b0}, {16'h8, 16'h0, 1'b0}, {16'h9, 16'h0, 1'b0},
    {16'hA, 16'h0, 1'b0}, {16'h1, 16'h0, 1'b1}, {16'hB, 16'h0, 1'b1}};
  logic [32:0] wr_tab [27] = '{{16'h2, 16'h03E7, 1'b1}, {16'h2, 16'h05DC, 1'b1},
    {16'h2, 16'h2328, 1'b1}, {16'h2, 16'h1F40, 1'b0}, {16'h2, 16'h03E8, 1'b0},
    {16'h3, 16'h0010, 1'b1}, {16'h4, 16'h0010, 1'b1}, {16'h5, 16'h0010, 1'b1},
    {16'h6, 16'h0028, 1'b1}, {16'h6, 16'h01CC, 1'b1}, {16'h6, 16'h01CB, 1'b0},
    {16'h6, 16'h0064, 1'b0}, {16'h7, 16'h0321, 1'b1}, {16'h7, 16'h012C, 1'b0},
    {16'h8, 16'h028A, 1'b1}, {16'h8, 16'h03E9, 1'b1}, {16'h8, 16'h02BC, 1'b0},
    {16'h9, 16'h0000, 1'b1}, {16'h9, 16'h0002, 1'b1}, {16'h9, 16'hFFFD, 1'b1},
    {16'h9, 16'hFFFB, 1'b0}, {16'h9, 16'h0003, 1'b0}, {16'hA, 16'h0003, 1'b1},
    {16'hA, 16'h0002, 1'b1}, {16'hA, 16'hFFFE, 1'b0}, {16'hA, 16'h0006, 1'b0},
    {16'hB, 16'h0001, 1'b1}};
  logic [32:0] rb_tab [6] = '{{16'h6, 16'h0064, 1'b0}, {16'h7, 16'h012C, 1'b0},
    {16'h8, 16'h02BC, 1'b0}, {16'h9, 16'h0003, 1'b0}, {16'hA, 16'h0006, 1'b0},
    {16'h2, 16'h03E8, 1'b0}};

  always #50 ref_clk_i = ~ref_clk_i;

  ring_master_model u_ring_master_model (.ref_clk_i(ref_clk_i), .mst_end_o(mst_end),
    .byte_o(mdt_byte), .valid_o(mdt_valid), .sof_o(mdt_sof), .start_us_o(t_start),
    .dur_us_o(t_dur), .proc_us_o(t_proc));

  drive_cyclic_telegram_timing u_drive_cyclic_telegram_timing (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .comm_phase_i(comm_phase_i), .mst_end_i(mst_end),
    .mdt_byte_i(mdt_byte), .mdt_valid_i(mdt_valid), .mdt_sof_i(mdt_sof),
    .mdt_start_time_us_i(t_start), .mdt_duration_us_i(t_dur),
    .cmd_process_time_us_i(t_proc), .param_wr_i(param_wr_i), .param_rd_i(param_rd_i),
    .param_idn_i(param_idn_i), .param_wdata_i(param_wdata_i), .rec_ready_i(rec_ready_i),
    .param_rdata_o(param_rdata_o), .param_ack_o(param_ack_o), .param_err_o(param_err_o),
    .cycle_start_o(cycle_start_o), .sync_missed_o(sync_missed_o),
    .answer_start_o(answer_start_o), .feedback_latch_o(feedback_latch_o),
    .cmd_valid_o(cmd_valid_o), .interp_step_o(interp_step_o),
    .interp_enable_o(interp_enable_o), .mdt_ready_o(mdt_ready_o),
    .rec_data_o(rec_data_o), .rec_valid_o(rec_valid_o), .rec_overflow_o(rec_overflow_o));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ack is a one-cycle pulse, so it is looked for at every falling edge
  task automatic wait_ack();
    for (int i = 0; i < 4 && param_ack_o !== 1'b1; i++) @(negedge ref_clk_i);
    if (param_ack_o !== 1'b1) begin
      bad_count++;
      $display("[FAIL] parameter ack missing");
      close_out();
    end
  endtask

  task automatic pwr(input logic [32:0] w);
    @(negedge ref_clk_i);
    param_wr_i = 1'b1;
    param_idn_i = w[32:17];
    param_wdata_i = w[16:1];
    @(negedge ref_clk_i);
    param_wr_i = 1'b0;
    wait_ack();
    `CHK("write refused", w[0], param_err_o)
  endtask

  task automatic prd(input logic [32:0] w);
    @(negedge ref_clk_i);
    param_rd_i = 1'b1;
    param_idn_i = w[32:17];
    @(negedge ref_clk_i);
    param_rd_i = 1'b0;
    wait_ack();
    `CHK("read refused", w[0], param_err_o)
    `CHK("read data", w[16:1], param_rdata_o)
  endtask

  initial begin
    repeat (40000) @(negedge ref_clk_i);
    bad_count++;
    $display("[FAIL] run did not complete");
    close_out();
  end

  initial begin
    repeat (5) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    foreach (rst_tab[i]) prd(rst_tab[i]);
    pwr({`IDX_CYCLE_PERIOD, 16'h0BB8, 1'b1});
    comm_phase_i = `PHASE_LOAD;
    for (int i = 0; i < 5; i++) pwr(wr_tab[i]);
    prd({`IDX_FEEDBACK_CAPTURE, 16'h0320, 1'b0});
    for (int i = 5; i < 27; i++) pwr(wr_tab[i]);
    foreach (rb_tab[i]) prd(rb_tab[i]);
    u_ring_master_model.send_mdt(4'h0, 8);
    `CHK("taken before run", 1'b0, rec_valid_o)
    comm_phase_i = `PHASE_RUN;
    repeat (2) @(negedge ref_clk_i);
    pwr({`IDX_CYCLE_PERIOD, 16'h03E8, 1'b1});
    `CHK("interp on", 1'b1, interp_enable_o)
    u_ring_master_model.sync_pulse();
    for (int j = 1; j <= 10300; j++) begin
      if (answer_start_o && t_ans == 0) t_ans = j;
      if (feedback_latch_o && t_fb == 0) t_fb = j;
      if (cmd_valid_o && t_cmd == 0) t_cmd = j;
      if (interp_step_o && j <= 10000) n_int++;
      if (cycle_start_o) n_cyc++;
      @(negedge ref_clk_i);
    end
    `CHK("answer cycle", 1001, t_ans)
    `CHK("capture cycle", 3001, t_fb)
    `CHK("command cycle", 7001, t_cmd)
    `CHK("sub-steps", 4, n_int)
    `CHK("cycle starts", 2, n_cyc)
    `CHK("sync missed", 1'b1, sync_missed_o)
    u_ring_master_model.sync_pulse();
    `CHK("sync missed clear", 1'b0, sync_missed_o)
    comm_phase_i = `PHASE_OPERATE;
    pwr({`IDX_CYCLE_PERIOD, 16'h03E8, 1'b1});
    // consumer stalls through three telegrams so the buffer must refuse
    for (int t = 1; t <= 3; t++) u_ring_master_model.send_mdt(4'(t), 8);
    `CHK("overflow", 1'b1, rec_overflow_o)
    `CHK("room", 1'b0, mdt_ready_o)
    rec_ready_i = 1'b1;
    for (int k = 0; k < 8; k++) begin
      `CHK("rec byte", {1'b1, 4'(1 + k / 4), 4'(3 + k % 4)}, {rec_valid_o, rec_data_o})
      @(negedge ref_clk_i);
    end
    `CHK("drained", 1'b0, rec_valid_o)
    comm_phase_i = `PHASE_LOAD;
    pwr({`IDX_CYCLE_PERIOD, 16'h1388, 1'b0});
    comm_phase_i = `PHASE_RUN;
    repeat (2) @(negedge ref_clk_i);
    `CHK("interp off", 1'b0, interp_enable_o)
    close_out();
  end
endmodule
`default_nettype wire
